// ### core/sync_sram_128k_by_9.sv
// Function
// - read when write strobe high, chip select and output gate low at edge
// - read word at registered address lands in output register next edge
// - write when chip select and write strobe low; store sampled data
// - array write self-timed inside the cycle, no external pulse needed
// - deselect cycles perform neither write nor internal read
// - after a deselect the data pins float for the next cycle
// - deselect by chip select enters low-power standby for that cycle
// - all sampling and output updates on the rising clock edge only
// - 17-bit address captured every edge, selects one stored word
// - one 9-bit three-state bus carries write and read data
// - low write strobe writes regardless of output gate; device receives
// - data pins driven from output register, change only on rising edge
`include "sram_map.svh"

module sync_sram_128k_by_9
    import sram_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          resetn,
    // address and control
    input  wire word_addr_type wordAddr,
    input  wire logic          chipSelN,
    input  wire logic          writeStrobeN,
    input  wire logic          outGateN,
    // shared data bus
    input  wire data_word_type sharedDataBusIn,
    output data_word_type      sharedDataBusOut,
    output logic               sharedDataBusOeN,
    // status
    output logic               lowPowerStandby
);

    ctrl_state_type state_ff;
    ctrl_state_type nxt_state;
    data_word_type  arrayRdData;
    logic           arrayWrEn;
    logic           arrayRdEn;
    cycle_mode_type sampledMode;

    // truth table; write strobe is checked before output gate
    function automatic cycle_mode_type decodeMode(
        input logic csN,
        input logic weN,
        input logic oeN
    );
        cycle_mode_type m;
        if (csN == `SRAM_PIN_INACTIVE) begin
            m = MODE_DESEL_CS;
        end else if (weN == `SRAM_PIN_ACTIVE) begin
            m = MODE_WRITE;
        end else if (oeN == `SRAM_PIN_ACTIVE) begin
            m = MODE_READ;
        end else begin
            m = MODE_DESEL_IDLE;
        end
        return m;
    endfunction

    assign sampledMode = decodeMode(chipSelN, writeStrobeN, outGateN);

    always_comb begin
        nxt_state        = state_ff;
        // input registers load on every edge, wanted or not
        nxt_state.addr   = wordAddr;
        nxt_state.wrData = sharedDataBusIn;
        nxt_state.mode   = sampledMode;
        // drive the cycle after a read; never into a cycle that writes
        nxt_state.driveN = `SRAM_PIN_INACTIVE;
        if ((state_ff.mode == MODE_READ) && (sampledMode != MODE_WRITE)) begin
            nxt_state.driveN = `SRAM_PIN_ACTIVE;
        end
        nxt_state.standby = (sampledMode == MODE_DESEL_CS);
    end

    // only the rising edge is used, so duty cycle does not matter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff.addr    <= `SRAM_RST_ADDR;
            state_ff.wrData  <= `SRAM_RST_DATA;
            state_ff.mode    <= MODE_DESEL_CS;
            state_ff.driveN  <= `SRAM_RST_DRIVE_N;
            state_ff.standby <= `SRAM_RST_STANDBY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // array access runs in the cycle after sampling, from the input registers
    always_comb begin
        arrayWrEn = 1'b0;
        arrayRdEn = 1'b0;
        case (state_ff.mode)
            MODE_WRITE: begin
                arrayWrEn = 1'b1;
            end
            MODE_READ: begin
                arrayRdEn = 1'b1;
            end
            MODE_DESEL_CS,
            MODE_DESEL_IDLE: begin
                arrayWrEn = 1'b0;
                arrayRdEn = 1'b0;
            end
            default: begin
                arrayWrEn = 1'b0;
                arrayRdEn = 1'b0;
            end
        endcase
    end

    // no array reset: stored words are unknown until first written
    sram_word_array sram_word_array_i (
        .mclk   (mclk),
        .wrEn   (arrayWrEn),
        .wrAddr (state_ff.addr),
        .wrData (state_ff.wrData),
        .rdEn   (arrayRdEn),
        .rdAddr (state_ff.addr),
        .rdData (arrayRdData)
    );

    // output register holds the last word read; enable gates the pins
    assign sharedDataBusOut = arrayRdData;
    assign sharedDataBusOeN = state_ff.driveN;
    assign lowPowerStandby  = state_ff.standby;

endmodule

// ### core/sram_map.svh
`ifndef SRAM_MAP_SVH
`define SRAM_MAP_SVH

// array geometry
`define SRAM_ADDR_W      17
`define SRAM_DATA_W      9
`define SRAM_WORD_COUNT  131072

// cycles from the sampling edge to data on the shared bus
`define SRAM_READ_LATENCY 1

// control pin levels, all active low
`define SRAM_PIN_ACTIVE   1'b0
`define SRAM_PIN_INACTIVE 1'b1

// values held by control state while reset is asserted
`define SRAM_RST_ADDR     17'h00000
`define SRAM_RST_DATA     9'h000
`define SRAM_RST_DRIVE_N  1'b1
`define SRAM_RST_STANDBY  1'b1

`endif

// ### core/sram_pkg.sv
`include "sram_map.svh"

package sram_pkg;

    typedef logic [`SRAM_ADDR_W-1:0] word_addr_type;
    typedef logic [`SRAM_DATA_W-1:0] data_word_type;

    // cycle mode as sampled on a rising edge
    typedef enum logic [1:0] {
        MODE_DESEL_CS   = 2'b00,
        MODE_DESEL_IDLE = 2'b01,
        MODE_READ       = 2'b10,
        MODE_WRITE      = 2'b11
    } cycle_mode_type;

    typedef struct packed {
        word_addr_type  addr;
        data_word_type  wrData;
        cycle_mode_type mode;
        logic           driveN;
        logic           standby;
    } ctrl_state_type;

endpackage

// ### core/sram_word_array.sv
`include "sram_map.svh"

module sram_word_array
    import sram_pkg::*;
(
    // clock
    input  wire logic          mclk,
    // write port
    input  wire logic          wrEn,
    input  wire word_addr_type wrAddr,
    input  wire data_word_type wrData,
    // read port
    input  wire logic          rdEn,
    input  wire word_addr_type rdAddr,
    output data_word_type      rdData
);

    // no reset: contents are undefined until written
    data_word_type memWords [`SRAM_WORD_COUNT];
    data_word_type rdData_ff;

    // write and read both commit on the edge that closes the access cycle
    always_ff @(posedge mclk) begin
        if (wrEn) begin
            memWords[wrAddr] <= wrData;
        end
        if (rdEn) begin
            rdData_ff <= memWords[rdAddr];
        end
    end

    assign rdData = rdData_ff;

endmodule

// ### sim/sync_sram_128k_by_9_checker.sv
module sram_checker
    import sram_pkg::*;
(
    // watched ports
    input logic          mclk,
    input logic          resetn,
    input logic          chipSelN,
    input logic          writeStrobeN,
    input logic          outGateN,
    input data_word_type sharedDataBusOut,
    input logic          sharedDataBusOeN,
    input logic          lowPowerStandby
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // output register is unknown until the first read reaches the pins
    logic outSeen_ff;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            outSeen_ff <= 1'b0;
        end else if (!sharedDataBusOeN) begin
            outSeen_ff <= 1'b1;
        end
    end
    sequence rd;
        !chipSelN && writeStrobeN && !outGateN;
    endsequence
    sequence wr;
        !chipSelN && !writeStrobeN;
    endsequence
    // pins follow a read one edge late, and never into a cycle that writes
    a_read_drive: assert property (rd ##1 (chipSelN || writeStrobeN)
        |=> !sharedDataBusOeN) else $error("no drive");
    a_read_burst: assert property (rd ##1 rd ##1 (chipSelN || writeStrobeN)
        |-> !sharedDataBusOeN [*2]) else $error("gap in burst");
    a_write_yield: assert property (wr |=> sharedDataBusOeN [*2])
        else $error("drove on write");
    a_idle_float: assert property (!chipSelN && writeStrobeN && outGateN
        |=> !lowPowerStandby ##1 sharedDataBusOeN) else $error("idle drove");
    a_cs_sleep: assert property (chipSelN
        |=> lowPowerStandby ##1 sharedDataBusOeN) else $error("no standby");
    a_sel_awake: assert property (!chipSelN |=> !lowPowerStandby) else $error("standby");
    a_out_hold: assert property (outSeen_ff
        && !(!chipSelN && writeStrobeN && !outGateN) |=> ##1 $stable(sharedDataBusOut))
        else $error("out moved");
    a_drive_cause: assert property (!sharedDataBusOeN
        |-> $past(!chipSelN && writeStrobeN && !outGateN, 2)) else $error("stray drive");
endmodule

bind sync_sram_128k_by_9 sram_checker sram_checker_i (.mclk, .resetn, .chipSelN,
    .writeStrobeN, .outGateN, .sharedDataBusOut, .sharedDataBusOeN, .lowPowerStandby);

// ### sim/sram_host_model.sv
module sram_host_model
    import sram_pkg::*;
(
    // bus parties
    input  data_word_type sharedDataBusOut,
    input  logic          sharedDataBusOeN,
    input  logic          hostDrive,
    input  data_word_type hostData,
    // level on the wire
    output data_word_type sharedDataBusIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven: inverse of the device word, so a stale copy never passes
    assign sharedDataBusIn = !sharedDataBusOeN ? sharedDataBusOut
        : hostDrive ? hostData : ~sharedDataBusOut; // host writes
endmodule

// ### sim/sync_sram_128k_by_9_tb_top.sv
module sync_sram_128k_by_9_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sram_pkg::*;
    logic          mclk = 1'h0, resetn = 1'h0, sharedDataBusOeN, lowPowerStandby;
    logic [2:0]    cwo = 3'h4;
    word_addr_type wordAddr = 17'h00000;
    data_word_type hostData = 9'h000, sharedDataBusIn, sharedDataBusOut;
    int            fails = 0, tests_run = 0;
    always #4 mclk = ~mclk;
    sync_sram_128k_by_9 sync_sram_128k_by_9_i (.mclk, .resetn, .wordAddr, .chipSelN(cwo[2]),
        .writeStrobeN(cwo[1]), .outGateN(cwo[0]), .sharedDataBusIn, .sharedDataBusOut,
        .sharedDataBusOeN, .lowPowerStandby);
    sram_host_model sram_host_model_i (.sharedDataBusOut, .sharedDataBusOeN,
        .hostDrive(!cwo[1]), .hostData, .sharedDataBusIn);
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %h %h", $time, seen, exp);
        end
    endtask
    task cyc(input logic [2:0] c, input int i, input data_word_type d);
        @(posedge mclk);
        cwo <= c;
        wordAddr <= ~17'(i);
        hostData <= d;
        #1;
    endtask
    task test_write_read;
        for (int i = 0; i < 4; i++)
            cyc({2'h0, i[0]}, i, 9'h155 ^ 9'(i)); // gate level ignored
        cyc(3'h4, 0, 9'h0AA); // gap; strobe low while deselected
        // pins show a read two edges after it is driven here
        for (int i = 0; i < 6; i++) begin
            cyc(i < 4 ? 3'h2 : 3'h6, i, 9'h000);
            if (i > 1)
                chk({sharedDataBusOeN, sharedDataBusOut}, {1'h0, 9'h155 ^ 9'(i - 2)});
        end
        $display("test_write_read done");
    endtask
    task test_deselect;
        cyc(3'h5, 1, 9'h0F0);
        cyc(3'h3, 1, 9'h000);
        chk({sharedDataBusOeN, lowPowerStandby}, 10'h003);
        cyc(3'h2, 1, 9'h000);
        chk({sharedDataBusOeN, lowPowerStandby}, 10'h002);
        cyc(3'h3, 1, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h356);
        cyc(3'h3, 1, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h154);
        cyc(3'h3, 1, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h354);
        $display("test_deselect done");
    endtask
    task test_turnaround;
        cyc(3'h2, 2, 9'h000);
        // two gaps: the read still holds the pins through the first one
        cyc(3'h3, 2, 9'h000);
        cyc(3'h3, 2, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h157);
        cyc(3'h0, 2, 9'h0C3);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h357);
        cyc(3'h2, 2, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h357);
        cyc(3'h3, 2, 9'h000);
        cyc(3'h3, 2, 9'h000);
        chk({sharedDataBusOeN, sharedDataBusOut}, 10'h0C3);
        $display("test_turnaround done");
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'h1;
        test_write_read;
        test_deselect;
        test_turnaround;
        end_of_test;
    end
    // about 32 cycles of traffic; a hang runs far past this
    initial begin
        #2000;
        fails++;
        end_of_test;
    end
endmodule
